// ==== jcfg_pkg.sv ====
/*
  jcfg_pkg: constants and types for the output configuration checker.
  assumes: rates are given as plain integers in Mbps and MSPS units.
*/
package jcfg_pkg;

  // quick configuration codes
  localparam logic [7:0] QC_N8_L1M1F1 = 8'h00;
  localparam logic [7:0] QC_N8_L1M1F2 = 8'h01;
  localparam logic [7:0] QC_N8_L2M1F1 = 8'h40;
  localparam logic [7:0] QC_N8_L2M1F2 = 8'h41;
  localparam logic [7:0] QC_N8_L2M1F4 = 8'h42;
  localparam logic [7:0] QC_N8_L4M1F1 = 8'h80;
  localparam logic [7:0] QC_N8_L4M1F2 = 8'h81;
  localparam logic [7:0] QC_N8_L1M2F2 = 8'h09;
  localparam logic [7:0] QC_N8_L2M2F1 = 8'h48;
  localparam logic [7:0] QC_N8_L2M2F2 = 8'h49;
  localparam logic [7:0] QC_N8_L4M2F1 = 8'h88;
  localparam logic [7:0] QC_N8_L4M2F2 = 8'h89;
  localparam logic [7:0] QC_N8_L4M2F4 = 8'h8a;
  localparam logic [7:0] QC_N8_L1M8F16 = 8'h1c;
  localparam logic [7:0] QC_N8_L2M8F8  = 8'h5b;
  localparam logic [7:0] QC_N16_L1M1F2 = 8'h01;

  // lane rate limits in Mbps
  localparam int unsigned LANE_MIN_MBPS  = 3125;
  localparam int unsigned LANE_MAX_MBPS  = 12500;
  localparam int unsigned LANE_FAST_MBPS = 6250;
  // sixteen-bit word lane rate factor for code 0x01
  localparam int unsigned N16_RATE_X     = 20;
  // lane rate factor is kept in tenths so 2.5 fits
  localparam int unsigned RATE_SCALE     = 10;

  // multiframe length limits
  localparam logic [5:0] K_MAX   = 6'h20;
  localparam logic [5:0] K_F1MIN = 6'h14;
  localparam logic [5:0] K_F2MIN = 6'h0c;
  localparam logic [5:0] K_F4MIN = 6'h08;
  localparam logic [5:0] K_F8MIN = 6'h04;

  // reset values
  localparam logic [4:0] RST_LANES = 5'h01;
  localparam logic [3:0] RST_CONVS = 4'h1;
  localparam logic [4:0] RST_OCTS  = 5'h01;

  typedef struct packed {
    logic [4:0]  lanes;
    logic [3:0]  convs;
    logic [4:0]  octets;
    logic [11:0] rate_x10;
    logic        known;
  } jcfg_map_s;

  typedef struct packed {
    logic        cfg_ok;
    logic        code_bad;
    logic        rate_bad;
    logic        k_bad;
    logic        lowrate_bad;
    logic        lowrate_want;
  } jcfg_stat_s;

  typedef enum logic [1:0] {
    JCFG_IDLE,
    JCFG_EVAL,
    JCFG_DONE
  } jcfg_state_e;

endpackage

// ==== jcfg_decode.sv ====
/*
  jcfg_decode: combinational quick configuration lookup.
  assumes: used inside jcfg_top, code and word mode are stable registers.
*/
`timescale 1ns/1ps
module jcfg_decode (
  // selection
  input  wire logic [7:0]             qcode,
  input  wire logic                   word16,
  // lookup result
  output jcfg_pkg::jcfg_map_s         map
);
  import jcfg_pkg::*;

  function automatic jcfg_map_s ent(input logic [4:0] l, input logic [3:0] m,
                                    input logic [4:0] f, input logic [11:0] r);
    jcfg_map_s e;
    e.lanes    = l;
    e.convs    = m;
    e.octets   = f;
    e.rate_x10 = r;
    e.known    = 1'b1;
    return e;
  endfunction

  always_comb begin
    map = '0;
    if (word16) begin
      // only the one sixteen-bit code is served here
      if (qcode == QC_N16_L1M1F2) begin
        map = ent(5'd1, 4'd1, 5'd2, 12'(N16_RATE_X * RATE_SCALE));
      end
    end else begin
      case (qcode)
        QC_N8_L1M1F1:  map = ent(5'd1, 4'd1, 5'd1, 12'd100);
        QC_N8_L1M1F2:  map = ent(5'd1, 4'd1, 5'd2, 12'd100);
        QC_N8_L2M1F1:  map = ent(5'd2, 4'd1, 5'd1, 12'd50);
        QC_N8_L2M1F2:  map = ent(5'd2, 4'd1, 5'd2, 12'd50);
        QC_N8_L2M1F4:  map = ent(5'd2, 4'd1, 5'd4, 12'd50);
        QC_N8_L4M1F1:  map = ent(5'd4, 4'd1, 5'd1, 12'd25);
        QC_N8_L4M1F2:  map = ent(5'd4, 4'd1, 5'd2, 12'd25);
        QC_N8_L1M2F2:  map = ent(5'd1, 4'd2, 5'd2, 12'd200);
        QC_N8_L2M2F1:  map = ent(5'd2, 4'd2, 5'd1, 12'd100);
        QC_N8_L2M2F2:  map = ent(5'd2, 4'd2, 5'd2, 12'd100);
        QC_N8_L4M2F1:  map = ent(5'd4, 4'd2, 5'd1, 12'd50);
        QC_N8_L4M2F2:  map = ent(5'd4, 4'd2, 5'd2, 12'd50);
        QC_N8_L4M2F4:  map = ent(5'd4, 4'd2, 5'd4, 12'd50);
        QC_N8_L1M8F16: map = ent(5'd1, 4'd8, 5'd16, 12'd1600);
        QC_N8_L2M8F8:  map = ent(5'd2, 4'd8, 5'd8, 12'd800);
        default:       map = '0;
      endcase
    end
  end
endmodule

// ==== jcfg_top.sv ====
/*
  jcfg_top: output configuration checker for the serial transmit link.
  assumes: inputs synchronous to sys_clk; software holds inputs stable
  while a check runs; the serial lanes themselves live elsewhere.
*/
// How it works
// - output sample rate is converter rate over chip decimation, lane rate scales from it.
// - lane rate must lie from 3.125 to 12.5 Gbps or the setting is refused.
// - one octet frames take K of 20..32 step 4, two octet frames K of 12..32 step 4.
// - four octet frames take K of 8..32 step 4, eight or sixteen octets K of 4..32 step 4.
// - code 0x1c is one lane eight converters sixteen octets, 0x5b two lanes eight octets.
// - code 0x49 is two lanes two converters two octets, 0x88 four lanes one octet.
// - in sixteen-bit words code 0x01 runs at twenty times the output sample rate.
`timescale 1ns/1ps
module jcfg_top #(
  parameter int unsigned RATE_W = 16
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  // configuration
  input  wire logic                 start,
  input  wire logic [7:0]           qcode,
  input  wire logic                 word16,
  input  wire logic [RATE_W-1:0]    adc_msps,
  input  wire logic [4:0]           chip_dec,
  input  wire logic [5:0]           k_frames,
  input  wire logic                 lowrate_en,
  // results
  output logic                      done,
  output logic                      link_ok,
  output jcfg_pkg::jcfg_stat_s      stat,
  output logic [RATE_W-1:0]         fout_msps,
  output logic [RATE_W+3:0]         lane_mbps,
  output logic [4:0]                lanes,
  output logic [3:0]                convs,
  output logic [4:0]                octets
);
  import jcfg_pkg::*;

  // below ten bits the upper lane limit no longer fits the lane width
  if (RATE_W < 10 || RATE_W > 24) begin : g_bad_rate_w
    $error("jcfg_top: RATE_W out of range");
  end

  function automatic logic k_ok(input logic [4:0] f, input logic [5:0] k);
    logic [5:0] kmin;
    kmin = K_F8MIN;
    case (f)
      5'd1:    kmin = K_F1MIN;
      5'd2:    kmin = K_F2MIN;
      5'd4:    kmin = K_F4MIN;
      default: kmin = K_F8MIN;
    endcase
    return (k[1:0] == 2'b00) && (k >= kmin) && (k <= K_MAX);
  endfunction

  function automatic logic lane_lt(input logic [RATE_W+3:0] v, input int unsigned lim);
    return v < (RATE_W+4)'(lim);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // lookup

  jcfg_map_s map;

  jcfg_decode u_dec (
    .qcode  (qcode),
    .word16 (word16),
    .map    (map)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state

  // control group
  jcfg_state_e             state_reg, state_next;
  logic                    done_reg, done_next;
  // capture group, latched on the take
  logic [RATE_W-1:0]       fout_reg, fout_next;
  jcfg_map_s               map_reg, map_next;
  // result group, written while evaluating
  logic [RATE_W+3:0]       lane_reg, lane_next;
  jcfg_stat_s              stat_reg, stat_next;
  logic                    ok_reg, ok_next;

  // phase strobes of the control state
  logic                    take;
  logic                    eval;

  // divider is one cycle of combinational work; decimation is small
  logic [RATE_W-1:0]       fout_calc;
  logic [RATE_W+15:0]      lane_x10;
  logic [RATE_W+3:0]       lane_calc;
  logic                    fast;
  logic                    rate_fail;
  logic                    k_fail;
  logic                    lowrate_fail;

  //////////////////////////////////////////////////////////////////////////////
  // control

  always_comb begin
    state_next = state_reg;
    done_next  = 1'b0;
    take       = 1'b0;
    eval       = 1'b0;
    case (state_reg)
      JCFG_IDLE: begin
        if (start) begin
          take       = 1'b1;
          state_next = JCFG_EVAL;
        end
      end
      JCFG_EVAL: begin
        eval       = 1'b1;
        state_next = JCFG_DONE;
      end
      JCFG_DONE: begin
        done_next  = 1'b1;
        state_next = JCFG_IDLE;
      end
      default: begin
        state_next = JCFG_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= JCFG_IDLE;
      done_reg  <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      done_reg  <= done_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // capture

  always_comb begin
    // rate inputs and code are taken together with start
    fout_calc = (chip_dec == 5'd0) ? '0 : adc_msps / RATE_W'(chip_dec);
    fout_next = fout_reg;
    map_next  = map_reg;
    if (take) begin
      fout_next = fout_calc;
      map_next  = map;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fout_reg <= '0;
      map_reg  <= '{lanes: RST_LANES, convs: RST_CONVS, octets: RST_OCTS,
                    rate_x10: 12'h000, known: 1'b0};
    end else if (clk_en) begin
      fout_reg <= fout_next;
      map_reg  <= map_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // results

  always_comb begin
    lane_x10     = (RATE_W+16)'(fout_reg) * (RATE_W+16)'(map_reg.rate_x10);
    lane_calc    = (RATE_W+4)'(lane_x10 / (RATE_W+16)'(RATE_SCALE));
    fast         = !lane_lt(lane_calc, LANE_FAST_MBPS);
    rate_fail    = lane_lt(lane_calc, LANE_MIN_MBPS) ||
                   !lane_lt(lane_calc, LANE_MAX_MBPS + 1);
    // k and the low rate bit are sampled one edge after the take
    k_fail       = !k_ok(map_reg.octets, k_frames);
    lowrate_fail = fast && lowrate_en;

    lane_next = lane_reg;
    stat_next = stat_reg;
    ok_next   = ok_reg;
    // a stale pass must not outlive the start of a new check
    if (take) begin
      ok_next = 1'b0;
    end
    if (eval) begin
      lane_next              = lane_calc;
      stat_next.code_bad     = !map_reg.known;
      stat_next.rate_bad     = rate_fail;
      stat_next.k_bad        = k_fail;
      stat_next.lowrate_want = !fast;
      stat_next.lowrate_bad  = lowrate_fail;
      stat_next.cfg_ok       = map_reg.known && !rate_fail &&
                               !k_fail && !lowrate_fail;
      ok_next                = stat_next.cfg_ok;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lane_reg <= '0;
      stat_reg <= '0;
      ok_reg   <= 1'b0;
    end else if (clk_en) begin
      lane_reg <= lane_next;
      stat_reg <= stat_next;
      ok_reg   <= ok_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign done      = done_reg;
  assign link_ok   = ok_reg;
  assign stat      = stat_reg;
  assign fout_msps = fout_reg;
  assign lane_mbps = lane_reg;
  assign lanes     = map_reg.lanes;
  assign convs     = map_reg.convs;
  assign octets    = map_reg.octets;
endmodule

// ==== jcfg_chk.sv ====
/* jcfg_chk: port assertions for jcfg_top.
   assumes: inputs stay stable while a check runs. */
`timescale 1ns/1ps
module jcfg_chk #(
  parameter int unsigned RATE_W = 16
) (
  // watched ports
  input wire logic                 sys_clk,
  input wire logic                 sys_rst,
  input wire logic                 clk_en,
  input wire logic [RATE_W-1:0]    adc_msps,
  input wire logic [4:0]           chip_dec,
  input wire logic [5:0]           k_frames,
  input wire logic                 lowrate_en,
  input wire logic                 done,
  input wire logic                 link_ok,
  input wire jcfg_pkg::jcfg_stat_s stat,
  input wire logic [RATE_W-1:0]    fout_msps,
  input wire logic [RATE_W+3:0]    lane_mbps,
  input wire logic [4:0]           octets
);
  import jcfg_pkg::*;
  logic [5:0] k_min;
  always_comb begin
    k_min = (octets == 5'h01) ? K_F1MIN : (octets == 5'h02) ? K_F2MIN :
            (octets == 5'h04) ? K_F4MIN : K_F8MIN;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_DONE_PULSE: assert property (done && clk_en |=> !done)
    else $error("done longer than one cycle");
  AST_OK_CAUSE: assert property (done |-> link_ok == stat.cfg_ok)
    else $error("link_ok differs from cfg_ok");
  AST_CODE_BAD: assert property (done && stat.code_bad |-> !link_ok)
    else $error("unknown code let link start");
  AST_RATE_RANGE: assert property (done && !stat.rate_bad |->
    lane_mbps >= LANE_MIN_MBPS && lane_mbps <= LANE_MAX_MBPS) else $error("lane rate out");
  AST_LOWRATE_WANT: assert property (done |-> stat.lowrate_want == (lane_mbps < LANE_FAST_MBPS))
    else $error("low rate advice wrong");
  AST_FAST_BIT: assert property (done && lane_mbps >= LANE_FAST_MBPS && lowrate_en |->
    stat.lowrate_bad)
    else $error("low rate bit at fast rate not flagged");
  AST_K_RULE: assert property (done && !stat.code_bad |-> stat.k_bad ==
    !(k_frames[1:0] == 2'h0 && k_frames >= k_min && k_frames <= K_MAX)) else $error("k check wrong");
  AST_FOUT: assert property (done && chip_dec != 5'h00 |->
    fout_msps == adc_msps / chip_dec) else $error("output rate wrong");
endmodule
bind jcfg_top jcfg_chk #(.RATE_W(RATE_W)) u_chk (.sys_clk, .sys_rst, .clk_en, .adc_msps, .chip_dec,
  .k_frames, .lowrate_en, .done, .link_ok, .stat, .fout_msps, .lane_mbps, .octets);

// ==== jcfg_rx_model.sv ====
/* jcfg_rx_model: far receiver picking the low rate bit.
   assumes: fed by jcfg_top results on done. */
`timescale 1ns/1ps
module jcfg_rx_model (
  // results seen
  input  wire logic        sys_clk,
  input  wire logic        done,
  input  wire logic        link_ok,
  input  wire logic [19:0] lane_mbps,
  // choice made
  output logic             lowrate_pick,
  output logic             lock
);
  always_ff @(posedge sys_clk) begin
    if (done) begin
      lowrate_pick <= lane_mbps < 20'd6250;
      lock <= link_ok && lane_mbps >= 20'd3125 && lane_mbps <= 20'd12500;
    end
  end
endmodule

// ==== jcfg_top_tb.sv ====
/* jcfg_top_tb: directed checks of jcfg_top.
   assumes: default RATE_W of 16. */
`timescale 1ns/1ps
module jcfg_top_tb;
  import jcfg_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, start = 1'b0, word16 = 1'b0;
  logic lowrate_en = 1'b0, done, link_ok, lowrate_pick, lock;
  logic [7:0]  qcode = 8'h00;
  logic [15:0] adc_msps = 16'h0000, fout_msps;
  logic [4:0]  chip_dec = 5'h01, lanes, octets;
  logic [5:0]  k_frames = 6'h20;
  logic [3:0]  convs;
  logic [19:0] lane_mbps;
  jcfg_stat_s  stat;
  int n_fail = 0, comparisons = 0;
  logic [23:0] ktab [10] = '{24'h881001, 24'h881400, 24'h490c00, 24'h490801, 24'h420800,
                             24'h420401, 24'h5b0400, 24'h5b1e01, 24'h5b2401, 24'h1c0400};
  always #5 sys_clk = ~sys_clk;
  jcfg_top dut (.sys_clk, .sys_rst, .clk_en, .start, .qcode, .word16, .adc_msps, .chip_dec,
    .k_frames, .lowrate_en, .done, .link_ok, .stat, .fout_msps, .lane_mbps, .lanes, .convs, .octets);
  jcfg_rx_model rx (.sys_clk, .done, .link_ok, .lane_mbps, .lowrate_pick, .lock);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // stall freezes clk_en after the take; done must wait for it
  task automatic run(input logic [7:0] c, input logic w, input logic [15:0] a,
                     input logic [4:0] d, input logic [5:0] k, input logic lr, input int stall);
    int i;
    @(posedge sys_clk);
    #1;
    {qcode, word16, adc_msps, chip_dec, k_frames, lowrate_en, start} = {c, w, a, d, k, lr, 1'b1};
    @(posedge sys_clk);
    #1;
    start = 1'b0;
    if (stall > 0) begin
      clk_en = 1'b0;
      repeat (stall) begin
        @(posedge sys_clk);
        #1;
        chk(done, 1'b0);
      end
      clk_en = 1'b1;
    end
    for (i = 0; i < 20 && done !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(done, 1'b1);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    chk({done, link_ok, stat, lanes, convs, octets}, {2'h0, 6'h00, 5'h01, 4'h1, 5'h01});
    run(8'h1c, 1'b0, 16'd1000, 5'd16, 6'd32, 1'b0, 5);
    chk({lanes, convs, octets, fout_msps}, {5'd1, 4'd8, 5'd16, 16'd62});
    run(8'h5b, 1'b0, 16'd1000, 5'd16, 6'd32, 1'b0, 0);
    chk({lanes, convs, octets}, {5'd2, 4'd8, 5'd8});
    $display("test codes done");
    run(8'h49, 1'b0, 16'd1000, 5'd1, 6'd32, 1'b0, 0);
    chk({lanes, convs, octets, lane_mbps, link_ok}, {5'd2, 4'd2, 5'd2, 20'd10000, 1'b1});
    run(8'h88, 1'b0, 16'd1000, 5'd1, 6'd32, 1'b0, 0);
    chk({lanes, convs, octets, lane_mbps, stat.lowrate_want}, {5'd4, 4'd2, 5'd1, 20'd5000, 1'b1});
    @(posedge sys_clk);
    #1;
    run(8'h88, 1'b0, 16'd1000, 5'd1, 6'd32, lowrate_pick, 0);
    @(posedge sys_clk);
    #1;
    chk({link_ok, stat.lowrate_bad, lock, lowrate_pick}, {1'b1, 1'b0, 1'b1, 1'b1});
    run(8'h49, 1'b0, 16'd1000, 5'd1, 6'd32, 1'b1, 0);
    chk({link_ok, stat.lowrate_bad}, {1'b0, 1'b1});
    $display("test low rate done");
    run(8'h80, 1'b0, 16'd1250, 5'd1, 6'd32, 1'b1, 0);
    chk({stat.rate_bad, link_ok}, 2'b01);
    run(8'h80, 1'b0, 16'd1249, 5'd1, 6'd32, 1'b1, 0);
    chk({stat.rate_bad, link_ok}, 2'b10);
    run(8'h00, 1'b0, 16'd1250, 5'd1, 6'd32, 1'b0, 0);
    chk({stat.rate_bad, lane_mbps}, {1'b0, 20'd12500});
    run(8'h00, 1'b0, 16'd1251, 5'd1, 6'd32, 1'b0, 0);
    chk(stat.rate_bad, 1'b1);
    run(8'h00, 1'b0, 16'd1000, 5'd0, 6'd32, 1'b0, 0);
    chk(stat.rate_bad, 1'b1);
    run(8'h00, 1'b0, 16'd1000, 5'd3, 6'd32, 1'b0, 0);
    chk(fout_msps, 16'd333);
    run(8'h01, 1'b1, 16'd500, 5'd1, 6'd32, 1'b0, 0);
    chk({lane_mbps, link_ok}, {20'd10000, 1'b1});
    run(8'h02, 1'b0, 16'd1000, 5'd1, 6'd32, 1'b0, 0);
    chk({stat.code_bad, link_ok}, 2'b10);
    run(8'h49, 1'b1, 16'd500, 5'd1, 6'd32, 1'b0, 0);
    chk({stat.code_bad, link_ok}, 2'b10);
    $display("test rates done");
    foreach (ktab[j]) begin
      run(ktab[j][23:16], 1'b0, 16'd1000, 5'd1, ktab[j][13:8], 1'b0, 0);
      chk(stat.k_bad, ktab[j][0]);
    end
    $display("test k done");
    tally_and_finish;
  end
endmodule
